// >>> rtl/tmr_timer8.sv
// 8-bit timer/counter with prescaler, waveform modes and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - timer tick is clock enable from base
// - select bit picks bus clock or oscillator
// - switching source may corrupt register contents
// - async count write raises busy until loaded
// - async writes load after two oscillator edges
// - mode field chooses four modes and TOP
// - compare update point and overflow point per mode
// - force strobe applies match in non-PWM modes
// - forced match sets no flag, no clear
// - force bit always reads zero
// - nonzero output mode drives pin if direction
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: match action, inverse at BOTTOM
// - fast PWM compare at TOP ignores match
// - phase PWM: up and down match actions
// - phase PWM compare at TOP acts at TOP
// - clock select picks prescaler division
// - clock select zero stops the counter
// - counter write suppresses next compare match
// - compare matched every tick, sets flag
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic timer_oscillator_pin,
  input wire logic compare_pin_dir,
  input wire logic [TMR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [TMR_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TMR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [TMR_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_output_pin,
  output logic compare_output_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic aw_got, w_got, wr_en, lane0;
  logic [TMR_AW-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic oscillator_select;
  tmr_ctrl_s ctrl_tmp, ctrl;
  logic [7:0] cnt_tmp, cmp_tmp, cmp_buf, cmp, count;
  logic [TMR_NBUF-1:0] pend, wr_q, ld, wr_now;
  logic [1:0] ecnt [TMR_NBUF];
  logic osc_s1, osc_s2, osc_s3, osc_edge, src_tick, tick;
  logic [9:0] psc;
  logic count_down, blk, match, match_pend, force_apply;
  logic compare_flag, overflow_flag, cmp_set, ovf_set;
  logic next_pin;
  tmr_mode_e mode;

  assign mode = tmr_mode_e'({ctrl.wgm_hi, ctrl.wgm_lo});
  assign lane0 = s_axi_wstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  assign wr_en = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr_q <= '0;
      wdata_q <= TMR_RST8;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TMR_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        // a write without lane 0 takes a zero byte
        wdata_q <= lane0 ? s_axi_wdata[7:0] : TMR_RST8;
      end
      if (wr_en) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_q)
          TMR_OFF_CTRL, TMR_OFF_COUNT, TMR_OFF_CMP,
          TMR_OFF_STAT, TMR_OFF_FLAG: s_axi_bresp <= TMR_RESP_OKAY;
          default: s_axi_bresp <= TMR_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte lane 0 gate remembered alongside the data
  logic wlane_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wlane_q <= 1'b0;
    end else if (clk_en && s_axi_wvalid && s_axi_wready) begin
      wlane_q <= lane0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= TMR_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= '0;
        s_axi_rresp <= TMR_RESP_OKAY;
        case (s_axi_araddr)
          // force bit is a strobe and never reads back
          TMR_OFF_CTRL: s_axi_rdata[6:0] <= ctrl_tmp[6:0];
          TMR_OFF_COUNT: s_axi_rdata[7:0] <= count;
          TMR_OFF_CMP: s_axi_rdata[7:0] <= cmp_tmp;
          TMR_OFF_STAT: begin
            s_axi_rdata[TMR_ST_ASYNC] <= oscillator_select;
            s_axi_rdata[TMR_ST_CNT_BUSY] <= pend[TMR_IX_CNT];
          end
          TMR_OFF_FLAG: begin
            s_axi_rdata[TMR_FL_CMP] <= compare_flag;
            s_axi_rdata[TMR_FL_OVF] <= overflow_flag;
          end
          default: s_axi_rresp <= TMR_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temporary registers written by software
  assign wr_now[TMR_IX_CNT] = wr_en && wlane_q && (waddr_q == TMR_OFF_COUNT);
  assign wr_now[TMR_IX_CMP] = wr_en && wlane_q && (waddr_q == TMR_OFF_CMP);
  assign wr_now[TMR_IX_CTL] = wr_en && wlane_q && (waddr_q == TMR_OFF_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_tmp <= '0;
      cnt_tmp <= TMR_RST8;
      cmp_tmp <= TMR_RST8;
      oscillator_select <= 1'b0;
    end else if (clk_en) begin
      if (wr_now[TMR_IX_CTL]) ctrl_tmp <= tmr_ctrl_s'(wdata_q);
      if (wr_now[TMR_IX_CNT]) cnt_tmp <= wdata_q;
      if (wr_now[TMR_IX_CMP]) cmp_tmp <= wdata_q;
      if (wr_en && wlane_q && waddr_q == TMR_OFF_STAT) begin
        oscillator_select <= wdata_q[TMR_ST_ASYNC];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator pin: two-flop synchroniser, then edge detect on the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else if (clk_en) begin
      osc_s1 <= timer_oscillator_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end
  assign osc_edge = osc_s2 && !osc_s3;

  ////////////////////////////////////////////////////////////////////////////
  // transfer from temporary to destination register, one lane per register
  // in synchronous mode the load follows the write by one cycle
  for (genvar i = 0; i < TMR_NBUF; i++) begin : g_xfer
    assign ld[i] = (wr_q[i] && !oscillator_select)
                || (pend[i] && osc_edge && ecnt[i] == TMR_SYNC_EDGES - 2'h1);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wr_q[i] <= 1'b0;
        pend[i] <= 1'b0;
        ecnt[i] <= 2'h0;
      end else if (clk_en) begin
        wr_q[i] <= wr_now[i];
        if (wr_now[i] && oscillator_select) begin
          // a fresh write restarts the transfer; set wins over the load
          pend[i] <= 1'b1;
          ecnt[i] <= 2'h0;
        end else if (!oscillator_select) begin
          // source switched: abandon transfers, contents not guaranteed
          pend[i] <= 1'b0;
          ecnt[i] <= 2'h0;
        end else if (ld[i]) begin
          pend[i] <= 1'b0;
          ecnt[i] <= 2'h0;
        end else if (pend[i] && osc_edge) begin
          ecnt[i] <= ecnt[i] + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and timer tick, used as a clock enable of aclk
  assign src_tick = clk_en && (oscillator_select ? osc_edge : 1'b1);
  assign tick = src_tick && (ctrl.cs != 3'h0)
             && ((psc & TMR_PSC_MASK[ctrl.cs]) == TMR_PSC_MASK[ctrl.cs]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc <= 10'h000;
    end else if (src_tick) begin
      psc <= psc + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and compare destinations; compare is double buffered in pwm
  assign force_apply = ld[TMR_IX_CTL] && ctrl_tmp.force_cmp && !ctrl_tmp.wgm_lo;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
      cmp_buf <= TMR_RST8;
      cmp <= TMR_RST8;
    end else if (clk_en) begin
      if (ld[TMR_IX_CTL]) begin
        ctrl <= ctrl_tmp;
        ctrl.force_cmp <= 1'b0;
      end
      if (ld[TMR_IX_CMP]) cmp_buf <= cmp_tmp;
      case (mode)
        TMR_NORMAL, TMR_CTC: cmp <= cmp_buf;
        TMR_PHASE: if (tick && !count_down && count == TMR_MAX) cmp <= cmp_buf;
        TMR_FAST: if (tick && count == TMR_MAX) cmp <= cmp_buf;
        default: cmp <= cmp_buf;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter; a load blocks the compare match of the next tick
  assign match = (count == cmp) && !blk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= TMR_RST8;
      count_down <= 1'b0;
      blk <= 1'b0;
    end else if (clk_en) begin
      if (ld[TMR_IX_CNT]) begin
        count <= cnt_tmp;
        blk <= 1'b1;
      end else if (tick) begin
        blk <= 1'b0;
        case (mode)
          TMR_NORMAL, TMR_FAST: count <= count + TMR_ONE8;
          TMR_CTC: count <= match ? TMR_BOTTOM : count + TMR_ONE8;
          TMR_PHASE: begin
            if (!count_down && count == TMR_MAX) begin
              count_down <= 1'b1;
              count <= count - TMR_ONE8;
            end else if (count_down && count == TMR_BOTTOM) begin
              count_down <= 1'b0;
              count <= count + TMR_ONE8;
            end else begin
              count <= count_down ? count - TMR_ONE8 : count + TMR_ONE8;
            end
          end
          default: count <= count + TMR_ONE8;
        endcase
      end
      if (mode != TMR_PHASE) count_down <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: match flag one tick after equality, set wins over clear
  assign cmp_set = tick && match_pend;
  assign ovf_set = tick && ((mode != TMR_PHASE && count == TMR_MAX)
                         || (mode == TMR_PHASE && count_down && count == TMR_BOTTOM));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_pend <= 1'b0;
      compare_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (clk_en) begin
      // a count load drops a match still waiting from before the write
      if (ld[TMR_IX_CNT]) begin
        match_pend <= 1'b0;
      end else if (tick) begin
        match_pend <= match;
      end
      if (cmp_set) begin
        compare_flag <= 1'b1;
      end else if (wr_en && wlane_q && waddr_q == TMR_OFF_FLAG && wdata_q[TMR_FL_CMP]) begin
        compare_flag <= 1'b0;
      end
      if (ovf_set) begin
        overflow_flag <= 1'b1;
      end else if (wr_en && wlane_q && waddr_q == TMR_OFF_FLAG && wdata_q[TMR_FL_OVF]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generator; a forced match touches only the output latch
  always_comb begin
    next_pin = compare_output_pin;
    if (force_apply) begin
      case (ctrl_tmp.com)
        TMR_COM_TGL: next_pin = !compare_output_pin;
        TMR_COM_CLR: next_pin = 1'b0;
        TMR_COM_SET: next_pin = 1'b1;
        default: next_pin = compare_output_pin;
      endcase
    end else if (tick) begin
      case (mode)
        TMR_NORMAL, TMR_CTC: begin
          if (match) begin
            case (ctrl.com)
              TMR_COM_TGL: next_pin = !compare_output_pin;
              TMR_COM_CLR: next_pin = 1'b0;
              TMR_COM_SET: next_pin = 1'b1;
              default: next_pin = compare_output_pin;
            endcase
          end
        end
        TMR_FAST: begin
          // mode 1 is reserved and does nothing
          if (ctrl.com[1]) begin
            if (match && cmp != TMR_MAX) next_pin = ctrl.com[0];
            if (count == TMR_MAX) next_pin = !ctrl.com[0];
          end
        end
        TMR_PHASE: begin
          if (ctrl.com[1]) begin
            if (cmp == TMR_MAX) begin
              // at TOP take the down-count result to keep symmetry
              if (!count_down && count == TMR_MAX) next_pin = !ctrl.com[0];
            end else if (match) begin
              next_pin = count_down ? !ctrl.com[0] : ctrl.com[0];
            end
          end
        end
        default: next_pin = compare_output_pin;
      endcase
    end
  end

  // pin latch and its driver enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_pin <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else if (clk_en) begin
      compare_output_pin <= next_pin;
      compare_output_pin_oe <= (ctrl.com != TMR_COM_OFF) && compare_pin_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  stopped_hold_a: assert property (
    (ctrl.cs == 3'h0 && !ld[TMR_IX_CNT]) |=> $stable(count))
    else $error("counter moved with no clock selected");
  ovf_at_max_a: assert property (
    (tick && mode == TMR_NORMAL && count == TMR_MAX && !ld[TMR_IX_CNT]) |=> overflow_flag && count == TMR_BOTTOM)
    else $error("overflow not set at MAX");
  flag_delay_a: assert property (
    (tick && match) ##1 tick |=> compare_flag)
    else $error("compare flag late");
  busy_set_a: assert property (
    (wr_now[TMR_IX_CNT] && oscillator_select) |=> pend[TMR_IX_CNT] || !oscillator_select)
    else $error("count busy not raised");
  force_quiet_a: assert property (
    (force_apply && !cmp_set && !ld[TMR_IX_CNT] && !tick) |=> !$rose(compare_flag) && $stable(count))
    else $error("forced match touched flag or counter");
  ctc_clear_a: assert property (
    (tick && mode == TMR_CTC && match && !ld[TMR_IX_CNT]) |=> count == TMR_BOTTOM)
    else $error("clear-on-compare did not clear");
  force_read_a: assert property (
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == TMR_OFF_CTRL) |=> !s_axi_rdata[TMR_CTRL_FORCE])
    else $error("force bit read back");
  block_match_a: assert property (
    (ld[TMR_IX_CNT] && !tick) ##1 tick |=> !match_pend)
    else $error("match after counter write");
  phase_turn_a: assert property (
    (tick && mode == TMR_PHASE && !count_down && count == TMR_MAX && !ld[TMR_IX_CNT])
      |=> count_down && count == TMR_MAX - TMR_ONE8)
    else $error("phase mode did not turn at TOP");
endmodule // tmr_timer8
`default_nettype wire

// >>> shared/tmr_pkg.sv
// constants, register map and types for the 8-bit timer/counter
`default_nettype none
package tmr_pkg;
  // bus geometry and answers
  localparam int TMR_AW = 8;
  localparam int TMR_DW = 32;
  localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] TMR_OFF_CTRL = 8'h00;
  localparam logic [7:0] TMR_OFF_COUNT = 8'h04;
  localparam logic [7:0] TMR_OFF_CMP = 8'h08;
  localparam logic [7:0] TMR_OFF_STAT = 8'h0C;
  localparam logic [7:0] TMR_OFF_FLAG = 8'h10;
  // field positions
  localparam int TMR_ST_ASYNC = 3;
  localparam int TMR_ST_CNT_BUSY = 2;
  localparam int TMR_FL_CMP = 1;
  localparam int TMR_FL_OVF = 0;
  localparam int TMR_CTRL_FORCE = 7;
  // counter landmarks and reset values
  localparam logic [7:0] TMR_MAX = 8'hFF;
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_RST8 = 8'h00;
  localparam logic [7:0] TMR_ONE8 = 8'h01;
  // temporary-register transfer: oscillator edges before the load
  localparam logic [1:0] TMR_SYNC_EDGES = 2'h2;
  // indices of the three buffered registers
  localparam int TMR_IX_CNT = 0;
  localparam int TMR_IX_CMP = 1;
  localparam int TMR_IX_CTL = 2;
  localparam int TMR_NBUF = 3;
  // compare output actions
  localparam logic [1:0] TMR_COM_OFF = 2'h0;
  localparam logic [1:0] TMR_COM_TGL = 2'h1;
  localparam logic [1:0] TMR_COM_CLR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;
  // prescaler tap masks, indexed by clock select
  localparam logic [9:0] TMR_PSC_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01F,
                                              10'h03F, 10'h07F, 10'h0FF, 10'h3FF};
  typedef enum logic [1:0] {TMR_NORMAL, TMR_PHASE, TMR_CTC, TMR_FAST} tmr_mode_e;
  typedef struct packed {
    logic force_cmp;
    logic wgm_lo;
    logic [1:0] com;
    logic wgm_hi;
    logic [2:0] cs;
  } tmr_ctrl_s;
endpackage
`default_nettype wire

// >>> verification/tmr_timer8_test.sv
// self-checking bench for the 8-bit timer/counter over its register bus
`timescale 1ns/1ps
`default_nettype none
module tmr_timer8_test;
  import tmr_pkg::*;
  logic aclk, aresetn, osc, dir, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin, oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int err_count, tests_run, h, a;

  // clk_en tied high: freezing is not a documented timer behaviour
  tmr_timer8 tmr_timer8_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(1'h1), .timer_oscillator_pin(osc),
    .compare_pin_dir(dir), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .compare_output_pin(pin), .compare_output_pin_oe(oe));

  // 200 MHz clock
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // reporting helpers
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // window check for counts that depend on prescaler phase
  task near(input int got, input int exp, input int tol);
    tests_run++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tmo;
    err_count++;
    $display("wrong value at %0t: got %h expected %h (no answer)", $time, 0, 1);
    final_report();
  endtask

  task run(input int n);
    repeat (n) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus master: payload held until taken, ready held until the answer
  task wr(input logic [7:0] ad, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        rs = bresp;
        bready <= 1'h0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  task rdr(input logic [7:0] ad);
    int n;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  function automatic logic [7:0] cw(input tmr_mode_e m, input logic [1:0] c, input logic [2:0] s);
    return {1'h0, m[0], c, m[1], s};
  endfunction

  // stop, load compare and count, clear flags, then start with the new control
  task setup(input logic [7:0] cmp, input logic [7:0] cnt, input logic [7:0] c);
    wr(TMR_OFF_CTRL, 8'h00);
    wr(TMR_OFF_CMP, cmp);
    wr(TMR_OFF_COUNT, cnt);
    wr(TMR_OFF_FLAG, 8'h03);
    wr(TMR_OFF_CTRL, c);
  endtask

  task osc_edge;
    @(posedge aclk);
    osc <= 1'h1;
    run(4);
    osc <= 1'h0;
    run(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    rdr(TMR_OFF_CTRL);
    chk(rd, 32'h0);
    rdr(TMR_OFF_COUNT);
    chk(rd, 32'h0);
    rdr(TMR_OFF_CMP);
    chk(rd, 32'h0);
    chk({oe, pin}, 32'h0);
    rdr(8'h20);
    chk(rs, TMR_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h20, 8'h55);
    chk(rs, TMR_RESP_SLVERR);
    $display("test reset done");
  endtask

  task t_stop_and_prescale;
    int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
    setup(8'hFF, 8'h33, cw(TMR_NORMAL, 2'h0, 3'h0));
    run(100);
    rdr(TMR_OFF_COUNT);
    chk(rd, 32'h33);
    for (int s = 1; s < 8; s++) begin
      setup(8'hFF, 8'h00, cw(TMR_NORMAL, 2'h0, s[2:0]));
      rdr(TMR_OFF_COUNT);
      a = int'(rd[7:0]);
      run(dv[s - 1] * 8);
      rdr(TMR_OFF_COUNT);
      // the two reads sit three bus cycles further apart than the wait
      near(int'(rd[7:0]) - a, (dv[s - 1] * 8 + 3) / dv[s - 1], 1);
    end
    $display("test prescale done");
  endtask

  task t_flags;
    setup(8'h80, 8'hF0, cw(TMR_NORMAL, 2'h0, 3'h1));
    run(300);
    rdr(TMR_OFF_FLAG);
    chk(rd, 32'h3);
    setup(8'h10, 8'h00, cw(TMR_CTC, 2'h0, 3'h1));
    run(600);
    rdr(TMR_OFF_COUNT);
    near(int'(rd[7:0]), 8, 8);
    rdr(TMR_OFF_FLAG);
    chk(rd, 32'h2);
    // equal at start: the load must hide that first match
    setup(8'h30, 8'h30, cw(TMR_NORMAL, 2'h0, 3'h1));
    run(40);
    rdr(TMR_OFF_FLAG);
    chk(rd, 32'h0);
    run(300);
    rdr(TMR_OFF_FLAG);
    chk(rd, 32'h3);
    $display("test flags done");
  endtask

  task t_force;
    logic [1:0] cm [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic ex [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
    setup(8'h00, 8'h00, cw(TMR_NORMAL, 2'h3, 3'h0));
    for (int i = 0; i < 4; i++) begin
      wr(TMR_OFF_CTRL, 8'h80 | cw(TMR_NORMAL, cm[i], 3'h0));
      run(2);
      chk({oe, pin}, {1'h1, ex[i]});
    end
    rdr(TMR_OFF_CTRL);
    chk(rd, cw(TMR_NORMAL, 2'h1, 3'h0));
    rdr(TMR_OFF_FLAG);
    chk(rd, 32'h0);
    dir <= 1'h0;
    run(3);
    chk(oe, 1'h0);
    dir <= 1'h1;
    wr(TMR_OFF_CTRL, cw(TMR_NORMAL, 2'h0, 3'h0));
    run(3);
    chk(oe, 1'h0);
    // software keeps the strobe zero in a pulse mode; pin must stay put
    wr(TMR_OFF_CTRL, cw(TMR_FAST, 2'h3, 3'h0));
    run(3);
    chk(pin, 1'h0);
    $display("test force done");
  endtask

  task t_pwm;
    tmr_mode_e md [8] = '{TMR_FAST, TMR_FAST, TMR_FAST, TMR_FAST, TMR_PHASE, TMR_PHASE, TMR_PHASE, TMR_PHASE};
    logic [7:0] cv [8] = '{8'h80, 8'h80, 8'hFF, 8'hFF, 8'h40, 8'h40, 8'hFF, 8'hFF};
    int ex [8] = '{258, 254, 512, 0, 256, 764, 1020, 0};
    int tl [8] = '{6, 6, 0, 0, 8, 8, 0, 0};
    for (int i = 0; i < 8; i++) begin
      setup(cv[i], 8'h00, cw(md[i], {1'h1, i[0]}, 3'h1));
      run(1100);
      h = 0;
      repeat ((md[i] == TMR_FAST) ? 512 : 1020) begin
        @(posedge aclk);
        if (pin === 1'h1) h++;
      end
      near(h, ex[i], tl[i]);
    end
    $display("test pwm done");
  endtask

  task t_async;
    setup(8'hFF, 8'h00, cw(TMR_NORMAL, 2'h0, 3'h0));
    wr(TMR_OFF_STAT, 8'h08);
    rdr(TMR_OFF_STAT);
    chk(rd[3], 1'h1);
    wr(TMR_OFF_COUNT, 8'h5A);
    rdr(TMR_OFF_STAT);
    chk(rd[2], 1'h1);
    osc_edge();
    run(8);
    rdr(TMR_OFF_STAT);
    chk(rd[2], 1'h1);
    repeat (4) osc_edge();
    rdr(TMR_OFF_STAT);
    chk(rd[2], 1'h0);
    rdr(TMR_OFF_COUNT);
    chk(rd, 32'h5A);
    // bus clock alone must not move the counter now
    wr(TMR_OFF_CTRL, cw(TMR_NORMAL, 2'h0, 3'h1));
    // two oscillator edges land the control word, then the bus clock alone runs
    repeat (2) osc_edge();
    run(50);
    rdr(TMR_OFF_COUNT);
    chk(rd, 32'h5A);
    repeat (8) osc_edge();
    rdr(TMR_OFF_COUNT);
    near(int'(rd[7:0]) - 8'h5A, 8, 2);
    wr(TMR_OFF_STAT, 8'h00);
    $display("test async done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    aresetn = 1'h0;
    osc = 1'h0;
    dir = 1'h1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    run(20);
    aresetn <= 1'h1;
    t_reset();
    t_stop_and_prescale();
    t_flags();
    t_force();
    t_pwm();
    t_async();
    final_report();
  end
endmodule // tmr_timer8_test
`default_nettype wire
